// ===== shared/sef_defines.svh
// Constants for the serial EEPROM front end
`ifndef SEF_DEFINES_SVH
`define SEF_DEFINES_SVH

// Byte and bit-counter geometry
`define SEF_BYTE_W 8
`define SEF_BITCNT_W 3
`define SEF_BIT_LAST 3'h7

// Memory geometry: 65536 x 8 array plus one 128-byte identification page
`define SEF_ADDR_W 16
`define SEF_ARRAY_BYTES 65536
`define SEF_ID_PAGE_BYTES 128

// Protected-size field positions and encodings
`define SEF_SIZE_HI_BIT 1
`define SEF_SIZE_LO_BIT 0
`define SEF_SIZE_NONE 2'h0
`define SEF_SIZE_QUARTER 2'h1
`define SEF_SIZE_HALF 2'h2
`define SEF_SIZE_WHOLE 2'h3

// Reset values
`define SEF_SIZE_RST 2'h0
`define SEF_BYTE_RST 8'h00

// Synchroniser depth
`define SEF_SYNC_STAGES 2

`endif

// ===== shared/sef_pkg.sv
// Types shared by the serial EEPROM front end
package sef_pkg;

    // One byte received from the serial line
    typedef struct packed {
        logic valid;
        logic first;
        logic [7:0] data;
    } sef_rx_t;

    // Selection and power state seen by the core
    typedef struct packed {
        logic selected;
        logic standby;
        logic armed;
    } sef_status_t;

    // Frame tracking on the system clock
    typedef enum logic [1:0] {
        SEF_WAIT_EDGE,
        SEF_IDLE,
        SEF_SELECTED
    } sef_state_t;

endpackage

// ===== rtl/sef_serial_front_end.sv
// Serial front end of a 64-Kbyte SPI EEPROM: shifting, select, hold and protect
`timescale 1ns/10ps
`include "sef_defines.svh"

// Summary of operation
// RULE_01 - Output bit changes on falling clock
// RULE_02 - Input bit captured on rising clock
// RULE_03 - Deselected means output tri-stated
// RULE_04 - Standby only when deselected, no write
// RULE_05 - Ignore instructions until select falling edge
// RULE_06 - Hold pauses transfer, keeps position
// RULE_07 - Hold tri-states output, ignores clock/data
// RULE_08 - Master holds only while selected
// RULE_09 - Write-protect pin freezes protected size
// RULE_10 - Master keeps protect pin stable
// RULE_11 - Input bytes most significant bit first
// RULE_12 - Output bytes MSB first after instruction
// RULE_13 - Clock modes 0/0 and 1/1 only
// RULE_14 - Master drives protect and hold pins
// RULE_15 - Array holds 65536 eight-bit bytes
// RULE_16 - Extra lockable 128-byte identification page
// RULE_17 - Hold starts only with clock low
// RULE_18 - Deselect during hold resets serial state
// RULE_19 - Select rising clears counter and shifter
module sef_serial_front_end
    import sef_pkg::*;
#(
    parameter int ADDR_W = `SEF_ADDR_W,
    parameter int ARRAY_BYTES = `SEF_ARRAY_BYTES,
    parameter int ID_PAGE_BYTES = `SEF_ID_PAGE_BYTES
) (
    input wire logic sys_clk,
    input wire logic rst,
    // Serial link pins
    input wire logic spi_clk,
    input wire logic spi_sel_n,
    input wire logic spi_hold_n,
    input wire logic spi_mosi,
    input wire logic spi_wp_n,
    output logic spi_miso_o,
    output logic spi_miso_oe,
    // Core side: received bytes
    output sef_rx_t rx_out,
    // Core side: byte to send on a read-type instruction
    input wire logic [7:0] tx_data,
    input wire logic tx_load,
    output logic tx_ready,
    // Core side: power and selection
    input wire logic write_busy,
    output sef_status_t status_out,
    // Core side: protected-size control
    input wire logic size_write,
    input wire logic protect_size_hi,
    input wire logic protect_size_lo,
    output logic [1:0] protect_size,
    output logic size_write_refused,
    input wire logic [ADDR_W-1:0] check_addr,
    output logic check_addr_protected,
    output logic any_protected,
    // Core side: identification page lock
    input wire logic id_lock,
    input wire logic id_write_req,
    output logic id_locked,
    output logic id_write_refused
);

    // RULE_15 array size check
    // RULE_16 identification page size check
    initial begin
        if (ARRAY_BYTES != (1 << ADDR_W)) begin
            $error("array size must equal two to the address width");
        end
        if (ID_PAGE_BYTES < 1 || ID_PAGE_BYTES > ARRAY_BYTES) begin
            $error("identification page size out of range");
        end
    end

    // Address falls inside the protected upper part of the array
    function automatic logic in_region(input logic [ADDR_W-1:0] a, input logic [1:0] sz);
        logic r;
        r = 1'b0;
        case (sz)
            `SEF_SIZE_NONE: r = 1'b0;
            `SEF_SIZE_QUARTER: r = (a[ADDR_W-1 -: 2] == 2'h3);
            `SEF_SIZE_HALF: r = a[ADDR_W-1];
            `SEF_SIZE_WHOLE: r = 1'b1;
            default: r = 1'b0;
        endcase
        return r;
    endfunction

    // ---------------- Link clock domain ----------------

    logic link_armed_reg;
    logic [`SEF_BITCNT_W-1:0] bit_cnt_reg;
    logic [6:0] rx_shift_reg;
    logic [7:0] rx_byte_reg;
    logic rx_first_reg;
    logic rx_tog_reg;
    logic byte_done_reg;
    logic [7:0] tx_shift_reg;
    logic tx_active_reg;
    logic tx_ack_tog_reg;
    logic [1:0] tx_pend_sync_reg;
    logic oe_drive_reg;
    logic rx_byte_first_reg;
    logic [7:0] tx_data_reg;
    logic tx_pend_reg;

    // RULE_05 armed by select falling edge
    always_ff @(negedge spi_sel_n or posedge rst) begin
        if (rst) begin
            link_armed_reg <= 1'b0;
        end else begin
            link_armed_reg <= 1'b1;
        end
    end

    // RULE_19 deselect clears shifter
    // RULE_18 deselect aborts held transfer
    always_ff @(posedge spi_clk or posedge spi_sel_n) begin
        if (spi_sel_n) begin
            bit_cnt_reg <= '0;
            rx_shift_reg <= '0;
            byte_done_reg <= 1'b0;
            rx_first_reg <= 1'b1;
        // RULE_07 hold ignores clock
        // RULE_17 hold taken with clock low
        end else if (spi_hold_n && link_armed_reg) begin
            // RULE_02 capture on rising edge
            // RULE_11 most significant bit first
            rx_shift_reg <= {rx_shift_reg[5:0], spi_mosi};
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            if (bit_cnt_reg == `SEF_BIT_LAST) begin
                byte_done_reg <= 1'b1;
            end
            if (byte_done_reg && bit_cnt_reg == 3'h0) begin
                rx_first_reg <= 1'b0;
            end
        end
    end

    // Completed byte and its event toggle survive deselection
    always_ff @(posedge spi_clk or posedge rst) begin
        if (rst) begin
            rx_byte_reg <= `SEF_BYTE_RST;
            rx_byte_first_reg <= 1'b0;
            rx_tog_reg <= 1'b0;
        end else if (!spi_sel_n && spi_hold_n && link_armed_reg && bit_cnt_reg == `SEF_BIT_LAST) begin
            rx_byte_reg <= {rx_shift_reg, spi_mosi};
            // Frame-start flag frozen with the byte, stable while the system side reads it
            rx_byte_first_reg <= rx_first_reg;
            rx_tog_reg <= ~rx_tog_reg;
        end
    end

    // Pending transmit flag brought onto the falling link edge
    always_ff @(negedge spi_clk or posedge rst) begin
        if (rst) begin
            tx_pend_sync_reg <= '0;
        end else begin
            tx_pend_sync_reg <= {tx_pend_sync_reg[0], tx_pend_reg};
        end
    end

    // RULE_01 output changes on falling edge
    // RULE_12 load at first falling edge after byte
    always_ff @(negedge spi_clk or posedge spi_sel_n) begin
        if (spi_sel_n) begin
            tx_shift_reg <= `SEF_BYTE_RST;
            tx_active_reg <= 1'b0;
            spi_miso_o <= 1'b0;
        // RULE_06 hold freezes output position
        end else if (spi_hold_n) begin
            if (byte_done_reg && bit_cnt_reg == 3'h0 && tx_pend_sync_reg[1]) begin
                spi_miso_o <= tx_data_reg[7];
                tx_shift_reg <= {tx_data_reg[6:0], 1'b0};
                tx_active_reg <= 1'b1;
            end else begin
                spi_miso_o <= tx_shift_reg[7];
                tx_shift_reg <= {tx_shift_reg[6:0], 1'b0};
            end
        end
    end

    // Acknowledge each byte taken for transmission
    always_ff @(negedge spi_clk or posedge rst) begin
        if (rst) begin
            tx_ack_tog_reg <= 1'b0;
        end else if (!spi_sel_n && spi_hold_n && byte_done_reg && bit_cnt_reg == 3'h0 && tx_pend_sync_reg[1]) begin
            tx_ack_tog_reg <= ~tx_ack_tog_reg;
        end
    end

    // RULE_03 deselect tri-states output
    // RULE_13 same edges in both clock modes
    always_ff @(negedge spi_clk or posedge spi_sel_n) begin
        if (spi_sel_n) begin
            oe_drive_reg <= 1'b0;
        end else if (spi_hold_n) begin
            oe_drive_reg <= tx_active_reg | (byte_done_reg && bit_cnt_reg == 3'h0 && tx_pend_sync_reg[1]);
        end
    end

    // RULE_07 hold tri-states output
    // Driving resumes as soon as hold ends, so the bit shown before the pause is not lost
    assign spi_miso_oe = oe_drive_reg & spi_hold_n;

    // ---------------- System clock domain ----------------

    logic [1:0] sel_sync_reg;
    logic [1:0] wp_sync_reg;
    logic [1:0] rx_tog_sync_reg;
    logic rx_tog_last_reg;
    logic [1:0] ack_sync_reg;
    logic ack_last_reg;
    sef_state_t state_reg;
    sef_state_t state_next;
    logic [1:0] size_reg;
    logic id_locked_reg;
    logic rx_event;
    logic ack_event;

    // Two-stage synchronisers for pins and link events
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            sel_sync_reg <= 2'h0;
            wp_sync_reg <= 2'h3;
            rx_tog_sync_reg <= '0;
            ack_sync_reg <= '0;
            rx_tog_last_reg <= 1'b0;
            ack_last_reg <= 1'b0;
        end else begin
            sel_sync_reg <= {sel_sync_reg[0], spi_sel_n};
            wp_sync_reg <= {wp_sync_reg[0], spi_wp_n};
            rx_tog_sync_reg <= {rx_tog_sync_reg[0], rx_tog_reg};
            ack_sync_reg <= {ack_sync_reg[0], tx_ack_tog_reg};
            rx_tog_last_reg <= rx_tog_sync_reg[1];
            ack_last_reg <= ack_sync_reg[1];
        end
    end

    assign rx_event = rx_tog_sync_reg[1] ^ rx_tog_last_reg;
    assign ack_event = ack_sync_reg[1] ^ ack_last_reg;

    // RULE_05 frame tracking needs a select falling edge
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            SEF_WAIT_EDGE: begin
                if (sel_sync_reg[1]) begin
                    state_next = SEF_IDLE;
                end
            end
            SEF_IDLE: begin
                if (!sel_sync_reg[1]) begin
                    state_next = SEF_SELECTED;
                end
            end
            SEF_SELECTED: begin
                if (sel_sync_reg[1]) begin
                    state_next = SEF_IDLE;
                end
            end
            default: state_next = SEF_WAIT_EDGE;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_reg <= SEF_WAIT_EDGE;
        end else begin
            state_reg <= state_next;
        end
    end

    // Received byte handed to the core for one cycle
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rx_out <= '0;
        end else begin
            rx_out.valid <= rx_event && state_reg != SEF_WAIT_EDGE;
            if (rx_event) begin
                rx_out.data <= rx_byte_reg;
                rx_out.first <= rx_byte_first_reg;
            end
        end
    end

    // Transmit byte holding register; set wins over acknowledge
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            tx_data_reg <= `SEF_BYTE_RST;
            tx_pend_reg <= 1'b0;
            tx_ready <= 1'b1;
        end else begin
            if (tx_load && !tx_pend_reg) begin
                tx_data_reg <= tx_data;
                tx_pend_reg <= 1'b1;
                tx_ready <= 1'b0;
            end else if (ack_event || state_reg != SEF_SELECTED) begin
                tx_pend_reg <= 1'b0;
                tx_ready <= 1'b1;
            end
        end
    end

    // RULE_04 standby only without write cycle
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            status_out <= '0;
        end else begin
            status_out.selected <= !sel_sync_reg[1] && state_reg != SEF_WAIT_EDGE;
            status_out.standby <= sel_sync_reg[1] && !write_busy;
            status_out.armed <= state_reg != SEF_WAIT_EDGE;
        end
    end

    // RULE_09 protect pin low freezes size
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            size_reg <= `SEF_SIZE_RST;
            size_write_refused <= 1'b0;
        end else begin
            size_write_refused <= size_write && !wp_sync_reg[1];
            if (size_write && wp_sync_reg[1]) begin
                size_reg[`SEF_SIZE_HI_BIT] <= protect_size_hi;
                size_reg[`SEF_SIZE_LO_BIT] <= protect_size_lo;
            end
        end
    end

    // Protection lookups on the frozen size
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            protect_size <= `SEF_SIZE_RST;
            check_addr_protected <= 1'b0;
            any_protected <= 1'b0;
        end else begin
            protect_size <= size_reg;
            check_addr_protected <= in_region(check_addr, size_reg);
            any_protected <= in_region({ADDR_W{1'b1}}, size_reg);
        end
    end

    // RULE_16 identification page permanent lock
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            id_locked_reg <= 1'b0;
            id_write_refused <= 1'b0;
        end else begin
            if (id_lock) begin
                id_locked_reg <= 1'b1;
            end
            id_write_refused <= id_write_req && id_locked_reg;
        end
    end

    assign id_locked = id_locked_reg;

endmodule

// ===== tb/sef_chk.sv
// Concurrent checks on the front end's pin and core outputs
`timescale 1ns/10ps
module sef_chk
    import sef_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic spi_sel_n,
    input wire logic spi_hold_n,
    input wire logic spi_miso_oe,
    input wire sef_rx_t rx_out,
    input wire logic tx_load,
    input wire logic tx_ready,
    input wire logic write_busy,
    input wire sef_status_t status_out,
    input wire logic size_write,
    input wire logic [1:0] protect_size,
    input wire logic size_write_refused,
    input wire logic check_addr_protected,
    input wire logic id_write_req,
    input wire logic id_locked,
    input wire logic id_write_refused
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    sequence busy_run;
        write_busy [*2];
    endsequence
    sequence whole_run;
        (protect_size == 2'h3) [*3];
    endsequence
    AST_DESEL_HIZ: assert property (spi_sel_n |-> !spi_miso_oe)
        else $error("output enabled while deselected");
    AST_HOLD_HIZ: assert property (!spi_hold_n |-> !spi_miso_oe)
        else $error("output enabled during hold");
    AST_RX_PULSE: assert property (rx_out.valid |=> !rx_out.valid)
        else $error("receive strobe longer than one cycle");
    AST_TX_TAKEN: assert property (tx_load && tx_ready |=> !tx_ready)
        else $error("transmit byte not taken");
    AST_BUSY_STANDBY: assert property (busy_run |-> !status_out.standby)
        else $error("standby during write cycle");
    AST_SIZE_FROZEN: assert property (!$past(size_write) && !$past(size_write, 2) |-> $stable(protect_size))
        else $error("protected size changed without request");
    AST_REFUSE_CAUSE: assert property (size_write_refused |-> $past(size_write) || $past(size_write, 2))
        else $error("refusal without size request");
    AST_ID_REFUSE: assert property (id_write_req && id_locked |=> id_write_refused)
        else $error("write to locked page not refused");
    AST_WHOLE_PROT: assert property (whole_run |-> check_addr_protected)
        else $error("address unprotected with whole array locked");
endmodule

bind sef_serial_front_end sef_chk chk (.sys_clk, .rst, .spi_sel_n, .spi_hold_n, .spi_miso_oe, .rx_out, .tx_load,
    .tx_ready, .write_busy, .status_out, .size_write, .protect_size, .size_write_refused, .check_addr_protected,
    .id_write_req, .id_locked, .id_write_refused);

// ===== tb/sef_spi_master.sv
// Serial bus master model for the front end's link pins
`timescale 1ns/10ps
module sef_spi_master (
    output logic spi_clk,
    output logic spi_sel_n,
    output logic spi_hold_n,
    output logic spi_mosi,
    input wire logic miso_line
);
    localparam int HALF = 24;
    logic cpol;
    initial begin
        cpol = 1'b0;
        spi_clk = 1'b0;
        spi_sel_n = 1'b0;
        spi_hold_n = 1'b1;
        spi_mosi = 1'b0;
    end
    task automatic begin_frame(input logic mode3);
        #7;
        cpol = mode3;
        spi_clk = mode3;
        #(HALF);
        spi_sel_n = 1'b0;
        #(HALF);
    endtask
    task automatic xfer(input logic [7:0] d, input int nbits, input int hold_at, output logic [7:0] q);
        q = 8'h00;
        for (int i = 7; i >= 8 - nbits; i--) begin
            spi_clk = 1'b0;
            if (i == hold_at) begin
                #(HALF / 2);
                spi_hold_n = 1'b0;
                repeat (2) begin
                    #(HALF / 2);
                    spi_mosi = ~spi_mosi;
                    spi_clk = 1'b1;
                    #(HALF);
                    spi_clk = 1'b0;
                end
                #(HALF / 2);
                spi_hold_n = 1'b1;
                #(HALF / 2);
            end
            spi_mosi = d[i];
            #(HALF);
            spi_clk = 1'b1;
            q[i] = miso_line;
            #(HALF);
        end
    endtask
    task automatic end_frame();
        spi_clk = cpol;
        #(HALF);
        spi_mosi = ~spi_mosi;
        spi_sel_n = 1'b1;
        #(10 * HALF);
    endtask
    task automatic hold_abort();
        spi_clk = 1'b0;
        #(HALF / 2);
        spi_hold_n = 1'b0;
        #(HALF / 2);
        spi_sel_n = 1'b1;
        #(HALF / 2);
        spi_hold_n = 1'b1;
        #(10 * HALF);
    endtask
endmodule

// ===== tb/sef_serial_front_end_test.sv
// Self-checking bench for the serial EEPROM front end
`timescale 1ns/10ps
module sef_serial_front_end_test;
    import sef_pkg::*;
    logic sys_clk, rst, spi_clk, spi_sel_n, spi_hold_n, spi_mosi, spi_wp_n, spi_miso_o, spi_miso_oe, miso_last;
    logic tx_load, tx_ready, write_busy, size_write, protect_size_hi, protect_size_lo, size_write_refused;
    logic check_addr_protected, any_protected, id_lock, id_write_req, id_locked, id_write_refused, seen;
    logic [7:0] tx_data, q;
    logic [1:0] protect_size;
    logic [15:0] check_addr;
    logic [8:0] rxq[$];
    sef_rx_t rx_out;
    sef_status_t status_out;
    int mismatches = 0;
    int tests_run = 0;
    wire miso_line = spi_miso_oe ? spi_miso_o : miso_last;
    sef_serial_front_end dut (.sys_clk, .rst, .spi_clk, .spi_sel_n, .spi_hold_n, .spi_mosi, .spi_wp_n, .spi_miso_o,
        .spi_miso_oe, .rx_out, .tx_data, .tx_load, .tx_ready, .write_busy, .status_out, .size_write, .protect_size_hi,
        .protect_size_lo, .protect_size, .size_write_refused, .check_addr, .check_addr_protected, .any_protected,
        .id_lock, .id_write_req, .id_locked, .id_write_refused);
    sef_spi_master mst (.spi_clk, .spi_sel_n, .spi_hold_n, .spi_mosi, .miso_line);
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    initial miso_last = 1'b0;
    always @(negedge spi_miso_oe) miso_last = ~spi_miso_o;
    always @(posedge sys_clk) if (rx_out.valid === 1'b1) rxq.push_back({rx_out.first, rx_out.data});
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic chk_rx(input logic [8:0] exp);
        chk("received byte", exp, (rxq.size() != 0) ? rxq.pop_front() : 9'h0ff);
    endtask
    task automatic strobe(ref logic s, ref logic w);
        @(negedge sys_clk) s = 1'b1;
        seen = 1'b0;
        repeat (3) @(negedge sys_clk) begin
            s = 1'b0;
            seen |= w;
        end
    endtask
    task automatic print_verdict();
        $display("Checks run %0d, mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        #1000000;
        mismatches++;
        print_verdict();
    end
    initial begin
        {rst, spi_wp_n} = 2'h3;
        {tx_load, write_busy, size_write, protect_size_hi, protect_size_lo, id_lock, id_write_req} = 7'h00;
        tx_data = 8'h00;
        check_addr = 16'h0000;
        repeat (3) @(posedge sys_clk);
        @(negedge sys_clk) rst = 1'b0;
        mst.xfer(8'h5a, 8, -1, q);
        mst.end_frame();
        chk("unarmed bytes", 0, rxq.size());
        for (int m3 = 0; m3 < 2; m3++) begin
            mst.begin_frame(m3[0]);
            repeat (4) @(negedge sys_clk);
            chk("status selected", 3'h5, status_out);
            tx_data = 8'h96 + 8'(m3);
            strobe(tx_load, tx_ready);
            mst.xfer(8'ha5, 8, -1, q);
            mst.xfer(8'h3c, 8, -1, q);
            chk("read byte", 8'h96 + 8'(m3), q);
            mst.end_frame();
            chk("ready after send", 1, tx_ready);
            chk_rx(9'h1a5);
            chk_rx(9'h03c);
        end
        mst.begin_frame(1'b0);
        repeat (4) @(negedge sys_clk);
        tx_data = 8'h69;
        strobe(tx_load, tx_ready);
        mst.xfer(8'hc3, 8, -1, q);
        mst.xfer(8'h0f, 8, 4, q);
        mst.end_frame();
        chk("read after hold", 8'h69, q);
        chk_rx(9'h1c3);
        chk_rx(9'h00f);
        mst.begin_frame(1'b0);
        mst.xfer(8'hff, 3, -1, q);
        mst.hold_abort();
        mst.begin_frame(1'b0);
        mst.xfer(8'h81, 8, -1, q);
        mst.end_frame();
        chk_rx(9'h181);
        for (int s = 0; s < 4; s++) begin
            {protect_size_hi, protect_size_lo} = 2'(s);
            strobe(size_write, size_write_refused);
            check_addr = 16'hc000;
            repeat (3) @(negedge sys_clk);
            chk("upper quarter", s != 0, check_addr_protected);
            check_addr = 16'hbfff;
            repeat (3) @(negedge sys_clk);
            chk("below quarter", s >= 2, check_addr_protected);
            check_addr = 16'h7fff;
            repeat (3) @(negedge sys_clk);
            chk("lower half", s == 3, check_addr_protected);
            chk("any protected", s != 0, any_protected);
        end
        // protect pin changed between writes only
        spi_wp_n = 1'b0;
        {protect_size_hi, protect_size_lo} = 2'h0;
        repeat (4) @(negedge sys_clk);
        strobe(size_write, size_write_refused);
        chk("size refused", 1, seen);
        chk("frozen size", 2'h3, protect_size);
        spi_wp_n = 1'b1;
        strobe(id_write_req, id_write_refused);
        chk("unlocked write", 0, seen);
        strobe(id_lock, id_locked);
        chk("lock kept", 1, id_locked);
        strobe(id_write_req, id_write_refused);
        chk("locked write", 1, seen);
        chk("standby idle", 1, status_out.standby);
        write_busy = 1'b1;
        repeat (4) @(negedge sys_clk);
        chk("standby busy", 0, status_out.standby);
        write_busy = 1'b0;
        print_verdict();
    end
endmodule
